// [core/smb_dev.sv]
// Device end: link slave with pointer, limit check, alert and timeout.
// Assumes the controller end meets it through smb_if, and that the
// reading input comes from logic on clk.
`timescale 1ns/10ps
`include "smb_map.svh"
module smb_dev import smb_pkg::*; #(
    parameter int unsigned TimeoutCycles = `SMB_TIMEOUT_MS * `SMB_CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst,
    smb_if.dev bus,
    input wire logic addrEnStrap,
    input wire logic addrSelStrap,
    input wire logic [9:0] reading,
    output logic alertActive,
    output logic linkBusy
);
    // ==========================================================
    // Elaboration check
    if (TimeoutCycles < 2 || TimeoutCycles >= (1 << 20)) begin : gChk
        $error("TimeoutCycles out of range");
    end
    localparam logic [19:0] TO_LAST = 20'(TimeoutCycles - 1);

    // ==========================================================
    // Pin synchronisers
    logic sclS1_r, sclS2_r, sclD_r, sdaS1_r, sdaS2_r, sdaD_r;
    logic enS1_r, enS2_r, selS1_r, selS2_r;

    // Every pin passes two flops before any logic reads it.
    always_ff @(posedge clk) begin
        if (rst) begin
            {sclS1_r, sclS2_r, sclD_r} <= 3'h7;
            {sdaS1_r, sdaS2_r, sdaD_r} <= 3'h7;
            {enS1_r, enS2_r, selS1_r, selS2_r} <= 4'hA;
        end else begin
            {sclS1_r, sclS2_r, sclD_r} <= {bus.scl, sclS1_r, sclS2_r};
            {sdaS1_r, sdaS2_r, sdaD_r} <= {bus.sda, sdaS1_r, sdaS2_r};
            {enS1_r, enS2_r} <= {addrEnStrap, enS1_r};
            {selS1_r, selS2_r} <= {addrSelStrap, selS1_r};
        end
    end

    // Line events; start and stop are data edges while the clock is high.
    wire sclRise = sclS2_r & ~sclD_r;
    wire sclFall = ~sclS2_r & sclD_r;
    wire startCond = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
    wire stopCond = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
    wire activity = (sclS2_r ^ sclD_r) | (sdaS2_r ^ sdaD_r);

    // ==========================================================
    // Registers and state
    smb_dstate_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] rxSh_r, rxSh_nxt, txSh_r, txSh_nxt, ptr_r, ptr_nxt;
    logic sdaOe_r, sdaOe_nxt, ackOn_r, ackOn_nxt, rw_r, rw_nxt;
    logic ara_r, ara_nxt, first_r, first_nxt;
    logic wrEn, rdTake, lockNow;
    logic [7:0] cfg_r, low_r, high_r, reading_r, status_r;
    logic alert_r, busy_r, locked_r;
    logic [6:0] ownAddr_r;
    logic [19:0] toCnt_r;

    // ==========================================================
    // Decoding
    wire [7:0] byteIn = {rxSh_r[6:0], sdaS2_r};
    wire [6:0] strapAddr = enS2_r ? `SMB_ADDR_DEFAULT :
        (selS2_r ? `SMB_ADDR_SEL1 : `SMB_ADDR_SEL0);
    // Once latched the straps no longer matter.
    wire [6:0] curAddr = locked_r ? ownAddr_r : strapAddr;
    wire matchOwn = byteIn[7:1] == curAddr;
    // The alert address is only answered for reads while alerting.
    wire matchAra = (byteIn[7:1] == `SMB_ADDR_ARA) & byteIn[0]
        & alert_r;
    wire violation = (reading_r > high_r) | (reading_r < low_r);
    wire [7:0] rdData =
        (ptr_r == `SMB_REG_READING) ? reading_r :
        (ptr_r == `SMB_REG_CONFIG) ? cfg_r :
        (ptr_r == `SMB_REG_STATUS) ? status_r :
        (ptr_r == `SMB_REG_LOW) ? low_r :
        (ptr_r == `SMB_REG_HIGH) ? high_r : 8'h00;
    wire [7:0] txLoad = ara_r ? {curAddr, 1'b0} : rdData;
    wire timeoutHit = ~cfg_r[`SMB_CFG_BUS_TIMEOUT_DISABLE]
        & (state_r != DS_IDLE) & (toCnt_r == TO_LAST);
    wire lastBit = cnt_r == 4'h7;

    // ==========================================================
    // Link state machine: samples on clock rise, drives after clock fall.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rxSh_nxt = rxSh_r;
        txSh_nxt = txSh_r;
        ptr_nxt = ptr_r;
        sdaOe_nxt = sdaOe_r;
        ackOn_nxt = ackOn_r;
        rw_nxt = rw_r;
        ara_nxt = ara_r;
        first_nxt = first_r;
        wrEn = 1'b0;
        rdTake = 1'b0;
        lockNow = 1'b0;
        if (timeoutHit) begin
            state_nxt = DS_IDLE;
            sdaOe_nxt = 1'b0;
        end else if (startCond) begin
            // A repeated start is taken in any state.
            state_nxt = DS_ADDR;
            cnt_nxt = 4'h0;
            sdaOe_nxt = 1'b0;
            ackOn_nxt = 1'b0;
        end else if (stopCond) begin
            state_nxt = DS_IDLE;
            sdaOe_nxt = 1'b0;
        end else begin
            case (state_r)
                DS_ADDR: begin
                    if (sclRise) begin
                        rxSh_nxt = byteIn;
                        cnt_nxt = cnt_r + 4'h1;
                        if (lastBit) begin
                            if (matchOwn) begin
                                lockNow = 1'b1;
                                rw_nxt = byteIn[0];
                                ara_nxt = 1'b0;
                                state_nxt = DS_ACKA;
                            end else if (matchAra) begin
                                rw_nxt = 1'b1;
                                ara_nxt = 1'b1;
                                state_nxt = DS_ACKA;
                            end else begin
                                state_nxt = DS_SKIP;
                            end
                        end
                    end
                end
                DS_ACKA, DS_ACKW: begin
                    // First fall pulls the ack, second fall ends it.
                    if (sclFall && !ackOn_r) begin
                        sdaOe_nxt = 1'b1;
                        ackOn_nxt = 1'b1;
                    end else if (sclFall) begin
                        ackOn_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        first_nxt = (state_r == DS_ACKA) | first_r;
                        if (state_r == DS_ACKA && rw_r) begin
                            state_nxt = DS_READ;
                            txSh_nxt = txLoad;
                            sdaOe_nxt = ~txLoad[7];
                            rdTake = ~ara_r;
                        end else begin
                            state_nxt = DS_WRITE;
                            sdaOe_nxt = 1'b0;
                        end
                    end
                end
                DS_WRITE: begin
                    if (sclRise) begin
                        rxSh_nxt = byteIn;
                        cnt_nxt = cnt_r + 4'h1;
                        if (lastBit) begin
                            state_nxt = DS_ACKW;
                            first_nxt = 1'b0;
                            if (first_r) begin
                                ptr_nxt = byteIn;
                            end else begin
                                wrEn = 1'b1;
                            end
                        end
                    end
                end
                DS_READ: begin
                    // A released one read back low means a lower address won.
                    if (sclRise && ara_r && !sdaOe_r && !sdaS2_r) begin
                        state_nxt = DS_SKIP;
                    end else if (sclRise) begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (lastBit) begin
                            state_nxt = DS_RDACK;
                        end
                    end else if (sclFall) begin
                        txSh_nxt = {txSh_r[6:0], 1'b0};
                        sdaOe_nxt = ~txSh_r[6];
                    end
                end
                DS_RDACK: begin
                    if (sclFall && !ackOn_r) begin
                        sdaOe_nxt = 1'b0;
                        ackOn_nxt = 1'b1;
                    end else if (sclRise && sdaS2_r) begin
                        state_nxt = DS_SKIP;
                        ackOn_nxt = 1'b0;
                    end else if (sclFall) begin
                        // Host acked: send the same register again.
                        ackOn_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        state_nxt = DS_READ;
                        txSh_nxt = txLoad;
                        sdaOe_nxt = ~txLoad[7];
                        rdTake = ~ara_r;
                    end
                end
                default: begin
                    sdaOe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Link state flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= DS_IDLE;
            {cnt_r, rxSh_r, txSh_r, ptr_r} <= 28'h0;
            {sdaOe_r, ackOn_r, rw_r, ara_r, first_r} <= 5'h0;
        end else begin
            state_r <= state_nxt;
            {cnt_r, rxSh_r, txSh_r, ptr_r} <=
                {cnt_nxt, rxSh_nxt, txSh_nxt, ptr_nxt};
            {sdaOe_r, ackOn_r, rw_r, ara_r, first_r} <=
                {sdaOe_nxt, ackOn_nxt, rw_nxt, ara_nxt, first_nxt};
        end
    end

    // Bus timeout counter restarts on any line edge and in idle.
    always_ff @(posedge clk) begin
        if (rst || activity || state_r == DS_IDLE) begin
            toCnt_r <= 20'h0;
        end else begin
            toCnt_r <= toCnt_r + 20'h1;
        end
    end

    // ==========================================================
    // Register file and limit status
    wire stsClr = rdTake & (ptr_r == `SMB_REG_STATUS);

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= `SMB_RST_CONFIG;
            low_r <= `SMB_RST_LOW;
            high_r <= `SMB_RST_HIGH;
            reading_r <= `SMB_RST_READING;
        end else begin
            reading_r <= reading[9:2];
            if (wrEn && ptr_r == `SMB_REG_CONFIG) cfg_r <= rxSh_nxt;
            if (wrEn && ptr_r == `SMB_REG_LOW) low_r <= rxSh_nxt;
            if (wrEn && ptr_r == `SMB_REG_HIGH) high_r <= rxSh_nxt;
        end
    end

    // Sticky status: a violation in the read cycle wins over the clear,
    // so the alert only drops once the reading is back inside limits.
    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= 8'h00;
            alert_r <= 1'b0;
        end else begin
            status_r[`SMB_STS_V25] <= violation
                | (status_r[`SMB_STS_V25] & ~stsClr);
            alert_r <= violation
                | (status_r[`SMB_STS_V25] & ~stsClr);
        end
    end

    // Address latch and busy flag.
    always_ff @(posedge clk) begin
        if (rst) begin
            locked_r <= 1'b0;
            ownAddr_r <= `SMB_ADDR_DEFAULT;
            busy_r <= 1'b0;
        end else begin
            if (lockNow && !locked_r) begin
                locked_r <= 1'b1;
                ownAddr_r <= strapAddr;
            end
            busy_r <= state_nxt != DS_IDLE;
        end
    end

    assign bus.devSdaOe = sdaOe_r;
    assign bus.devAlertOe = alert_r;
    assign alertActive = alert_r;
    assign linkBusy = busy_r;
endmodule

// [core/smb_map.svh]
// Constants shared by both ends of the two-wire management link.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH

// ==========================================================
// Link addresses
`define SMB_ADDR_DEFAULT 7'h2E
`define SMB_ADDR_SEL0 7'h2C
`define SMB_ADDR_SEL1 7'h2D
`define SMB_ADDR_ARA 7'h0C

// ==========================================================
// Device register offsets, reset values and fields
`define SMB_REG_READING 8'h20
`define SMB_REG_CONFIG 8'h40
`define SMB_REG_STATUS 8'h41
`define SMB_REG_LOW 8'h44
`define SMB_REG_HIGH 8'h45
`define SMB_RST_READING 8'h00
`define SMB_RST_CONFIG 8'h00
`define SMB_RST_LOW 8'h00
`define SMB_RST_HIGH 8'hFF
`define SMB_CFG_BUS_TIMEOUT_DISABLE 6
`define SMB_STS_V25 0

// ==========================================================
// Timing
`define SMB_TIMEOUT_MS 35
`define SMB_CLK_KHZ 25000
`define SMB_DIV_DEFAULT 62

// ==========================================================
// Controller register offsets and fields
`define SMB_APB_CTRL 12'h000
`define SMB_APB_ADDR 12'h004
`define SMB_APB_DATA 12'h008
`define SMB_APB_STAT 12'h00C
`define SMB_ST_BUSY 0
`define SMB_ST_NACK 1
`define SMB_ST_ALERT 2

// ==========================================================
// Controller operations and sequence items
`define SMB_OP_SEND 3'h0
`define SMB_OP_WRITE 3'h1
`define SMB_OP_RECV 3'h2
`define SMB_OP_ARA 3'h3
`define SMB_OP_SENDRD 3'h4
`define SMB_IT_START 3'h0
`define SMB_IT_STOP 3'h1
`define SMB_IT_TXAW 3'h2
`define SMB_IT_TXAR 3'h3
`define SMB_IT_TXCMD 3'h4
`define SMB_IT_TXDAT 3'h5
`define SMB_IT_RX 3'h6
`define SMB_IT_TXARA 3'h7

`endif

// [core/smb_pkg.sv]
// Types shared by both ends of the two-wire management link.
// Assumes nothing beyond a SystemVerilog compiler.
package smb_pkg;
    // Device link states.
    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_ACKA, DS_WRITE, DS_ACKW, DS_READ, DS_RDACK,
        DS_SKIP
    } smb_dstate_e;
    typedef logic [2:0] smb_item_t;
endpackage

// [core/smb_if.sv]
// Open-drain wiring of clock, data and alert between the two ends.
// Assumes both ends drive only enables; an enable high pulls low.
`timescale 1ns/10ps
interface smb_if;
    logic hostSclOe;
    logic hostSdaOe;
    logic devSdaOe;
    logic devAlertOe;
    wire scl;
    wire sda;
    wire alertLineN;

    // Wired-AND with pull-ups: any active enable pulls the line low.
    assign scl = ~hostSclOe;
    assign sda = ~(hostSdaOe | devSdaOe);
    assign alertLineN = ~devAlertOe;

    modport dev(input scl, input sda, output devSdaOe, output devAlertOe);
    modport host(output hostSclOe, output hostSdaOe, input scl, input sda,
        input alertLineN);
endinterface

// [core/smb_host.sv]
// Controller end: APB-programmed sequencer driving the two-wire link.
// Assumes a device end on smb_if and an APB master on clk.
`timescale 1ns/10ps
`include "smb_map.svh"
module smb_host import smb_pkg::*; #(
    parameter int unsigned DivCycles = `SMB_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    smb_if.host bus
);
    if (DivCycles < 4 || DivCycles > 255) begin : gChk
        $error("DivCycles out of range");
    end
    localparam logic [7:0] DIV_LAST = 8'(DivCycles - 1);

    // ==========================================================
    // Registers
    logic [2:0] op_r, item_r, lastIdx;
    logic [6:0] addr_r;
    logic [7:0] cmd_r, wdat_r, rdat_r, sh_r, div_r, txByte;
    logic busy_r, nack_r, sclOe_r, sdaOe_r, ready_r, err_r;
    logic [3:0] bit_r;
    logic [1:0] ph_r;
    logic [31:0] rdata_r;
    logic sdaS1_r, sdaS2_r, alS1_r, alS2_r;
    smb_item_t kind;
    logic [20:0] seq;

    // Sequence of items per operation, item 0 in the low bits.
    always_comb begin
        seq = 21'h0;
        lastIdx = 3'h3;
        case (op_r)
            `SMB_OP_SEND: seq = {9'h0, `SMB_IT_STOP, `SMB_IT_TXCMD,
                `SMB_IT_TXAW, `SMB_IT_START};
            `SMB_OP_WRITE: begin
                seq = {6'h0, `SMB_IT_STOP, `SMB_IT_TXDAT, `SMB_IT_TXCMD,
                    `SMB_IT_TXAW, `SMB_IT_START};
                lastIdx = 3'h4;
            end
            `SMB_OP_RECV: seq = {9'h0, `SMB_IT_STOP, `SMB_IT_RX,
                `SMB_IT_TXAR, `SMB_IT_START};
            `SMB_OP_ARA: seq = {9'h0, `SMB_IT_STOP, `SMB_IT_RX,
                `SMB_IT_TXARA, `SMB_IT_START};
            default: begin
                seq = {`SMB_IT_STOP, `SMB_IT_RX, `SMB_IT_TXAR,
                    `SMB_IT_START, `SMB_IT_TXCMD, `SMB_IT_TXAW,
                    `SMB_IT_START};
                lastIdx = 3'h6;
            end
        endcase
    end

    // ==========================================================
    // Decoding
    assign kind = seq[{item_r, 1'b0} + {2'h0, item_r} +: 3];
    assign txByte = (kind == `SMB_IT_TXAW) ? {addr_r, 1'b0} :
        (kind == `SMB_IT_TXAR) ? {addr_r, 1'b1} :
        (kind == `SMB_IT_TXARA) ? {`SMB_ADDR_ARA, 1'b1} :
        (kind == `SMB_IT_TXCMD) ? cmd_r : wdat_r;
    wire isRx = kind == `SMB_IT_RX;
    wire isByte = kind != `SMB_IT_START && kind != `SMB_IT_STOP;
    wire [7:0] curSh = (bit_r == 4'h0) ? txByte : sh_r;
    wire tick = busy_r && div_r == 8'h0;
    wire ackBit = bit_r == 4'h8;
    wire setupSeen = psel & ~penable;
    wire apbWr = psel & penable & ready_r & pwrite;
    wire startOp = apbWr && paddr == `SMB_APB_CTRL && !busy_r
        && pwdata[2:0] <= `SMB_OP_SENDRD;
    wire mapped = paddr == `SMB_APB_CTRL || paddr == `SMB_APB_ADDR
        || paddr == `SMB_APB_DATA || paddr == `SMB_APB_STAT;

    // Line inputs pass two flops before use.
    always_ff @(posedge clk) begin
        if (rst) begin
            {sdaS1_r, sdaS2_r, alS1_r, alS2_r} <= 4'hF;
        end else begin
            {sdaS1_r, sdaS2_r} <= {bus.sda, sdaS1_r};
            {alS1_r, alS2_r} <= {bus.alertLineN, alS1_r};
        end
    end

    // ==========================================================
    // APB slave: one wait-free access, answer registered in access phase.
    always_ff @(posedge clk) begin
        if (rst) begin
            {ready_r, err_r} <= 2'h0;
            rdata_r <= 32'h0;
            {addr_r, cmd_r, wdat_r} <= 23'h0;
        end else begin
            ready_r <= setupSeen;
            err_r <= setupSeen & ~mapped;
            rdata_r <= (paddr == `SMB_APB_STAT) ? {16'h0, rdat_r, 5'h0,
                ~alS2_r, nack_r, busy_r} :
                (paddr == `SMB_APB_ADDR) ? {25'h0, addr_r} :
                (paddr == `SMB_APB_DATA) ? {16'h0, wdat_r, cmd_r} :
                (paddr == `SMB_APB_CTRL) ? {29'h0, op_r} : 32'h0;
            if (apbWr && paddr == `SMB_APB_ADDR) addr_r <= pwdata[6:0];
            if (apbWr && paddr == `SMB_APB_DATA) begin
                {wdat_r, cmd_r} <= pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Bit engine: four ticks per bit, each tick DivCycles clocks.
    always_ff @(posedge clk) begin
        if (rst) begin
            {busy_r, nack_r, sclOe_r, sdaOe_r} <= 4'h0;
            {op_r, item_r, bit_r, ph_r} <= 12'h0;
            {div_r, sh_r, rdat_r} <= 24'h0;
        end else if (startOp) begin
            {busy_r, nack_r} <= 2'h2;
            op_r <= pwdata[2:0];
            {item_r, bit_r, ph_r, div_r} <= 17'h0;
        end else if (busy_r) begin
            div_r <= tick ? DIV_LAST : div_r - 8'h1;
            if (tick) begin
                ph_r <= ph_r + 2'h1;
                if (kind == `SMB_IT_START) begin
                    if (ph_r == 2'h0) sdaOe_r <= 1'b0;
                    if (ph_r == 2'h1) sclOe_r <= 1'b0;
                    if (ph_r == 2'h2) sdaOe_r <= 1'b1;
                    if (ph_r == 2'h3) begin
                        sclOe_r <= 1'b1;
                        item_r <= item_r + 3'h1;
                    end
                end else if (kind == `SMB_IT_STOP) begin
                    if (ph_r == 2'h0) sdaOe_r <= 1'b1;
                    if (ph_r == 2'h1) sclOe_r <= 1'b0;
                    if (ph_r == 2'h2) sdaOe_r <= 1'b0;
                    if (ph_r == 2'h3) busy_r <= 1'b0;
                end else if (isByte) begin
                    // Reads always end with a not-acknowledge.
                    if (ph_r == 2'h0) sdaOe_r <= !ackBit && !isRx
                        && !curSh[7];
                    if (ph_r == 2'h1) sclOe_r <= 1'b0;
                    if (ph_r == 2'h2 && ackBit && !isRx && sdaS2_r) begin
                        nack_r <= 1'b1;
                    end
                    if (ph_r == 2'h2 && !ackBit) begin
                        sh_r <= isRx ? {sh_r[6:0], sdaS2_r}
                            : {curSh[6:0], 1'b0};
                    end
                    if (ph_r == 2'h3) begin
                        sclOe_r <= 1'b1;
                        bit_r <= ackBit ? 4'h0 : bit_r + 4'h1;
                        if (ackBit && isRx) rdat_r <= sh_r;
                        if (ackBit) item_r <= nack_r ? lastIdx
                            : item_r + 3'h1;
                    end
                end
            end
        end
    end

    assign prdata = rdata_r;
    assign pready = ready_r;
    assign pslverr = err_r;
    assign bus.hostSclOe = sclOe_r;
    assign bus.hostSdaOe = sdaOe_r;
endmodule

// [dv/smb_monitor.sv]
// Link checker between the controller and device ends.
// Assumes DivCycles of 8 or more and the bus timeout never running out.
`timescale 1ns/10ps
module smb_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic hostSclOe,
    input wire logic hostSdaOe,
    input wire logic devSdaOe,
    input wire logic devAlertOe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Frame edges: a data edge while the clock line stays high.
    sequence linkStart;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence linkStop;
        scl && $past(scl) && $rose(sda);
    endsequence
    // The device may only move data while the clock is low.
    a_start_quiet: assert property (linkStart |=> !devSdaOe [*8])
        else $error("device drives data right after start");
    a_stop_quiet: assert property (linkStop |=> !devSdaOe [*8])
        else $error("device drives data right after stop");
    a_ack_rise: assert property ($rose(devSdaOe) |-> !scl)
        else $error("device pulls data while clock high");
    a_ack_fall: assert property ($fell(devSdaOe) |-> !scl)
        else $error("device releases data while clock high");
    a_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
        else $error("device data moved in clock high phase");
    a_scl_low: assert property ($rose(hostSclOe) |=> hostSclOe [*4])
        else $error("clock low phase too short");
    a_scl_high: assert property ($fell(hostSclOe) |=> !hostSclOe [*4])
        else $error("clock high phase too short");
    a_reset_idle: assert property ($fell(rst) |->
        !devSdaOe && !devAlertOe && !hostSclOe && !hostSdaOe)
        else $error("lines not released after reset");
endmodule

// [dv/tb_top.sv]
// Bench joining both link ends; drives the controller over APB.
// Assumes smb_map.svh on the include path and straps choosing 0x2E first.
`timescale 1ns/10ps
`include "smb_map.svh"
module tb_top;
    localparam logic [6:0] Own = `SMB_ADDR_DEFAULT;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic pready, pslverr, alertActive, linkBusy, v, bz;
    logic addrEn = 1, addrSel = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, st;
    logic [9:0] reading = 0;
    logic [7:0] lo, hi;
    logic [7:0] rr[4] = '{8'h44, 8'h45, 8'h20, 8'h40};
    logic [7:0] rv[4] = '{8'h00, 8'hFF, 8'h00, 8'h00};
    int mismatches = 0, total_checks = 0;
    smb_if bus();
    smb_dev #(.TimeoutCycles(2000)) u_smb_dev(.clk(clk), .rst(rst),
        .bus(bus.dev), .addrEnStrap(addrEn), .addrSelStrap(addrSel),
        .reading(reading), .alertActive(alertActive), .linkBusy(linkBusy));
    smb_host #(.DivCycles(8)) u_smb_host(.clk(clk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus.host));
    smb_monitor u_smb_monitor(.clk(clk), .rst(rst),
        .hostSclOe(bus.hostSclOe), .hostSdaOe(bus.hostSdaOe),
        .devSdaOe(bus.devSdaOe), .devAlertOe(bus.devAlertOe),
        .scl(bus.scl), .sda(bus.sda));
    // ==========================================================
    // Clock at 25 MHz.
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        st = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Start one link operation and poll until the controller is idle.
    task automatic op(input logic [2:0] o, input logic [6:0] a,
        input logic [15:0] d);
        apb(`SMB_APB_ADDR, 1'b1, {25'h0, a});
        apb(`SMB_APB_DATA, 1'b1, {16'h0, d});
        apb(`SMB_APB_CTRL, 1'b1, {29'h0, o});
        repeat (4) @(posedge clk);
        bz = 1'b0;
        // The device must have left idle during the frame and be back now.
        do begin
            apb(`SMB_APB_STAT, 1'b0, 0);
            bz = bz | linkBusy;
        end while (st[`SMB_ST_BUSY] !== 1'b0);
        chk(bz, 1'b1);
        chk(linkBusy, 1'b0);
    endtask
    function automatic logic viol(input logic [9:0] r, input logic [7:0] l,
        input logic [7:0] h);
        return (r[9:2] > h) || (r[9:2] < l);
    endfunction
    // Reset values, random limits with alert handling, refusals.
    initial begin
        void'($urandom(31));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rr[i]) begin
            op(`SMB_OP_SENDRD, Own, {8'h0, rr[i]});
            chk(st[15:8], rv[i]);
        end
        // Straps now select another address; the latched one must hold.
        addrEn <= 1'b0;
        apb(12'h010, 1'b0, 0);
        chk(err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            reading <= 10'($urandom);
            // Corners: limits that always trip, then limits that never do.
            lo = (i == 3) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom);
            hi = (i == 3) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
            op(`SMB_OP_WRITE, Own, {lo, `SMB_REG_LOW});
            op(`SMB_OP_RECV, Own, 0);
            chk(st[15:8], lo);
            op(`SMB_OP_WRITE, Own, {hi, `SMB_REG_HIGH});
            op(`SMB_OP_SEND, Own, {8'h0, `SMB_REG_READING});
            op(`SMB_OP_RECV, Own, 0);
            chk(st[15:8], reading[9:2]);
            op(`SMB_OP_SENDRD, Own, {8'h0, `SMB_REG_STATUS});
            v = viol(reading, lo, hi);
            chk(alertActive, v);
            chk(bus.alertLineN, !v);
            chk(st[`SMB_ST_ALERT], v);
            op(`SMB_OP_RECV, Own, 0);
            chk(st[15:8], {7'h0, v});
            op(`SMB_OP_SEND, `SMB_ADDR_ARA, 0);
            chk(st[`SMB_ST_NACK], 1'b1);
            op(`SMB_OP_ARA, `SMB_ADDR_ARA, 0);
            chk(st[`SMB_ST_NACK], !v);
            chk(v ? st[15:8] : 8'h5C, {Own, 1'b0});
        end
        op(`SMB_OP_RECV, `SMB_ADDR_SEL1, 0);
        chk(st[`SMB_ST_NACK], 1'b1);
        op(`SMB_OP_RECV, `SMB_ADDR_SEL0, 0);
        chk(st[`SMB_ST_NACK], 1'b1);
        op(`SMB_OP_WRITE, Own, {8'h40, `SMB_REG_CONFIG});
        op(`SMB_OP_SENDRD, Own, {8'h0, `SMB_REG_CONFIG});
        chk(st[15:8], 8'h40);
        stop_test;
    end
    // A hang ends the run as a mismatch.
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        stop_test;
    end
endmodule
